// file: np_port_pkg.sv
package np_port_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int SYNC_STAGES = 3;

  // Register select codes
  localparam logic [6:0] SEL_STATUS1_LOW  = 7'h00;
  localparam logic [6:0] SEL_STATUS1_HIGH = 7'h01;
  localparam logic [6:0] SEL_STATUS2_LOW  = 7'h02;
  localparam logic [6:0] SEL_STATUS2_HIGH = 7'h03;
  localparam logic [6:0] SEL_MASK1_LOW    = 7'h04;
  localparam logic [6:0] SEL_MASK1_HIGH   = 7'h05;
  localparam logic [6:0] SEL_MASK2_LOW    = 7'h06;
  localparam logic [6:0] SEL_MASK2_HIGH   = 7'h07;
  localparam logic [6:0] SEL_BUFFER_DATA  = 7'h08;
  localparam logic [6:0] SEL_SCRATCH      = 7'h09;
  localparam logic [6:0] SEL_STATE_READ   = 7'h0A;
  localparam logic [6:0] CMD_BASE         = 7'h40;

  localparam logic [15:0] RESET_MASK      = 16'h0000;
  localparam logic [15:0] RESET_SCRATCH   = 16'h0000;
  localparam logic [7:0]  RESET_OP_STATE  = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_WAITBUF = 5'b00010,
    ST_ACK     = 5'b00100,
    ST_HOLD    = 5'b01000,
    ST_SACK    = 5'b10000
  } port_state_t;

endpackage : np_port_pkg

// file: pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import np_port_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // Per bit: change accepted once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      level  <= INIT;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule : pin_sync
`default_nettype wire

// file: attention_line.sv
`timescale 1ns/100ps
`default_nettype none
module attention_line
  import np_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] flag_set,
  input  wire logic [31:0] mask,
  input  wire logic        read_low,
  input  wire logic        read_high,
  output logic      [31:0] status,
  output logic             line_n
);

  logic        armed;
  logic        low_seen;
  logic        high_seen;
  logic [31:0] next_status;
  logic        next_armed;
  logic        next_low_seen;
  logic        next_high_seen;
  logic        next_line_n;
  logic        both_read;

  always_comb
  begin
    next_status    = status | flag_set;
    next_armed     = armed;
    next_low_seen  = low_seen | read_low;
    next_high_seen = high_seen | read_high;
    both_read      = next_low_seen && next_high_seen;
    // Read half clears, but a new event in the same cycle wins
    if (read_low)
      next_status[15:0] = flag_set[15:0];
    if (read_high)
      next_status[31:16] = flag_set[31:16];
    if (read_low || read_high)
      next_armed = 1'b0;
    if (both_read)
    begin
      next_armed     = 1'b1;
      next_low_seen  = 1'b0;
      next_high_seen = 1'b0;
    end
    next_line_n = !(next_armed && |(next_status & mask));
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      status    <= 32'h0000_0000;
      armed     <= 1'b1;
      low_seen  <= 1'b0;
      high_seen <= 1'b0;
      line_n    <= 1'b1;
    end
    else
    begin
      status    <= next_status;
      armed     <= next_armed;
      low_seen  <= next_low_seen;
      high_seen <= next_high_seen;
      line_n    <= next_line_n;
    end
  end

endmodule : attention_line
`default_nettype wire

// file: node_processor_register_port.sv
// How it works
// - Strap high synchronous, low asynchronous handshake
// - Async: drive data when selected, strobed, reading
// - Sync: drive data when selected and reading
// - Sync: strobe latches register select bus
// - Select bus picks register, read or load
// - Some select codes act as commands
// - Async: acknowledge low once data moved
// - Async: release acknowledge after select/strobe high
// - Sync: acknowledge one byte-clock cycle
// - Sync: buffer window waits pending transfer
// - First attention on unmasked status1 flags
// - Status1 half read clears until fully read
// - Second attention on unmasked status2 flags
// - Status2 half read clears until fully read
// - Read/write high reads, low writes
`timescale 1ns/100ps
`default_nettype none
module node_processor_register_port
  import np_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        port_timing_strap,
  input  wire logic        chip_select_n,
  input  wire logic        port_data_strobe_n,
  input  wire logic        read_write,
  input  wire logic [6:0]  register_select_bus,
  input  wire logic [15:0] host_data_bus_in,
  output logic      [15:0] host_data_bus_out,
  output logic             host_data_bus_oe,
  output logic             ready_n_out,
  output logic             ready_n_oe,
  output logic             first_attention_line_out,
  output logic             first_attention_line_oe,
  output logic             second_attention_line_out,
  output logic             second_attention_line_oe,
  input  wire logic [31:0] status1_events,
  input  wire logic [31:0] status2_events,
  input  wire logic        buffer_transfer_pending,
  input  wire logic [15:0] buffer_read_data,
  output logic      [15:0] buffer_write_data,
  output logic             buffer_write_pulse,
  output logic             buffer_read_pulse,
  output logic      [7:0]  operating_state,
  output logic             command_pulse
);

  logic        strap_sync;
  logic        sync_mode;
  logic        cs_n_s;
  logic        strobe_n_s;
  logic        rw_s;
  logic        cs_n_a;
  logic        strobe_n_a;
  logic        rw_a;
  logic [6:0]  sel_a;
  logic [15:0] data_a;
  logic [6:0]  sel_latched;
  logic [6:0]  next_sel_latched;
  port_state_t state;
  port_state_t next_state;
  logic [15:0] mask1_low;
  logic [15:0] mask1_high;
  logic [15:0] mask2_low;
  logic [15:0] mask2_high;
  logic [15:0] scratch;
  logic [15:0] next_mask1_low;
  logic [15:0] next_mask1_high;
  logic [15:0] next_mask2_low;
  logic [15:0] next_mask2_high;
  logic [15:0] next_scratch;
  logic [7:0]  next_operating_state;
  logic [31:0] status1;
  logic [31:0] status2;
  logic        line1_n;
  logic        line2_n;
  logic [15:0] read_mux;
  logic [15:0] next_data_out;
  logic        next_data_oe;
  logic        next_ready_oe;
  logic        next_buffer_write_pulse;
  logic        next_buffer_read_pulse;
  logic        next_command_pulse;
  logic        access;
  logic        read_s1l;
  logic        read_s1h;
  logic        read_s2l;
  logic        read_s2h;
  logic        cyc_start;
  logic        cs_n_eff;
  logic        strobe_n_eff;
  logic        rw_eff;
  logic [6:0]  sel_eff;
  logic [15:0] data_eff;

  // Asynchronous-mode pins pass the three-stage filter
  pin_sync #(.WIDTH(26), .INIT({1'b1, 1'b1, 1'b1, 7'h00, 16'h0000})) u_pin_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in ({chip_select_n, port_data_strobe_n, read_write, register_select_bus, host_data_bus_in}),
    .level  ({cs_n_a, strobe_n_a, rw_a, sel_a, data_a})
  );

  pin_sync #(.WIDTH(1), .INIT(1'b0)) u_strap_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in (port_timing_strap),
    .level  (strap_sync)
  );

  // Synchronous mode samples the pins directly on the byte clock
  always_comb
  begin
    cs_n_s     = chip_select_n;
    strobe_n_s = port_data_strobe_n;
    rw_s       = read_write;
  end

  always_comb
  begin
    cs_n_eff     = sync_mode ? cs_n_s : cs_n_a;
    strobe_n_eff = sync_mode ? strobe_n_s : strobe_n_a;
    rw_eff       = sync_mode ? rw_s : rw_a;
    sel_eff      = sync_mode ? register_select_bus : sel_a;
    data_eff     = sync_mode ? host_data_bus_in : data_a;
    cyc_start    = !cs_n_eff && !strobe_n_eff;
  end

  attention_line u_att1 (
    .clk       (clk),
    .reset     (reset),
    .flag_set  (status1_events),
    .mask      ({mask1_high, mask1_low}),
    .read_low  (read_s1l),
    .read_high (read_s1h),
    .status    (status1),
    .line_n    (line1_n)
  );

  attention_line u_att2 (
    .clk       (clk),
    .reset     (reset),
    .flag_set  (status2_events),
    .mask      ({mask2_high, mask2_low}),
    .read_low  (read_s2l),
    .read_high (read_s2h),
    .status    (status2),
    .line_n    (line2_n)
  );

  always_comb
  begin
    case ((state == ST_IDLE) ? sel_eff : sel_latched)
      SEL_STATUS1_LOW:  read_mux = status1[15:0];
      SEL_STATUS1_HIGH: read_mux = status1[31:16];
      SEL_STATUS2_LOW:  read_mux = status2[15:0];
      SEL_STATUS2_HIGH: read_mux = status2[31:16];
      SEL_MASK1_LOW:    read_mux = mask1_low;
      SEL_MASK1_HIGH:   read_mux = mask1_high;
      SEL_MASK2_LOW:    read_mux = mask2_low;
      SEL_MASK2_HIGH:   read_mux = mask2_high;
      SEL_BUFFER_DATA:  read_mux = buffer_read_data;
      SEL_SCRATCH:      read_mux = scratch;
      SEL_STATE_READ:   read_mux = {8'h00, operating_state};
      default:          read_mux = 16'h0000;
    endcase
  end

  // Access point: register effect happens once per transfer
  always_comb
  begin
    next_state              = state;
    next_sel_latched        = sel_latched;
    next_mask1_low          = mask1_low;
    next_mask1_high         = mask1_high;
    next_mask2_low          = mask2_low;
    next_mask2_high         = mask2_high;
    next_scratch            = scratch;
    next_operating_state    = operating_state;
    next_buffer_write_pulse = 1'b0;
    next_buffer_read_pulse  = 1'b0;
    next_command_pulse      = 1'b0;
    next_ready_oe           = 1'b0;
    access                  = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (cyc_start)
        begin
          next_sel_latched = sel_eff;
          if (sel_eff == SEL_BUFFER_DATA && buffer_transfer_pending)
            next_state = ST_WAITBUF;
          else
          begin
            next_state = sync_mode ? ST_SACK : ST_ACK;
            access     = 1'b1;
          end
        end
      end
      ST_WAITBUF:
      begin
        if (!buffer_transfer_pending)
        begin
          next_state = sync_mode ? ST_SACK : ST_ACK;
          access     = 1'b1;
        end
      end
      ST_ACK:
      begin
        next_ready_oe = 1'b1;
        next_state    = ST_HOLD;
      end
      ST_HOLD:
      begin
        next_ready_oe = 1'b1;
        if (cs_n_eff || strobe_n_eff)
        begin
          next_ready_oe = 1'b0;
          next_state    = ST_IDLE;
        end
      end
      ST_SACK:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (access)
    begin
      if (state == ST_IDLE && sync_mode)
        next_ready_oe = 1'b1;
      else if (sync_mode)
        next_ready_oe = 1'b1;
      if (!rw_eff)
      begin
        case (next_sel_latched)
          SEL_MASK1_LOW:   next_mask1_low  = data_eff;
          SEL_MASK1_HIGH:  next_mask1_high = data_eff;
          SEL_MASK2_LOW:   next_mask2_low  = data_eff;
          SEL_MASK2_HIGH:  next_mask2_high = data_eff;
          SEL_SCRATCH:     next_scratch    = data_eff;
          SEL_BUFFER_DATA: next_buffer_write_pulse = 1'b1;
          default:         next_buffer_write_pulse = 1'b0;
        endcase
      end
      else if (next_sel_latched == SEL_BUFFER_DATA)
        next_buffer_read_pulse = 1'b1;
      if (next_sel_latched >= CMD_BASE)
      begin
        next_operating_state = {1'b0, next_sel_latched};
        next_command_pulse   = 1'b1;
      end
    end
    // Status half reads counted at the access point
    read_s1l = access && rw_eff && next_sel_latched == SEL_STATUS1_LOW;
    read_s1h = access && rw_eff && next_sel_latched == SEL_STATUS1_HIGH;
    read_s2l = access && rw_eff && next_sel_latched == SEL_STATUS2_LOW;
    read_s2h = access && rw_eff && next_sel_latched == SEL_STATUS2_HIGH;
  end

  always_comb
  begin
    if (sync_mode)
      next_data_oe = !cs_n_eff && rw_eff;
    else
      next_data_oe = !cs_n_eff && !strobe_n_eff && rw_eff;
    next_data_out = next_data_oe ? read_mux : 16'h0000;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync_mode                 <= 1'b0;
      state                     <= ST_IDLE;
      sel_latched               <= 7'h00;
      mask1_low                 <= RESET_MASK;
      mask1_high                <= RESET_MASK;
      mask2_low                 <= RESET_MASK;
      mask2_high                <= RESET_MASK;
      scratch                   <= RESET_SCRATCH;
      operating_state           <= RESET_OP_STATE;
      host_data_bus_out         <= 16'h0000;
      host_data_bus_oe          <= 1'b0;
      ready_n_out               <= 1'b0;
      ready_n_oe                <= 1'b0;
      first_attention_line_out  <= 1'b0;
      first_attention_line_oe   <= 1'b0;
      second_attention_line_out <= 1'b0;
      second_attention_line_oe  <= 1'b0;
      buffer_write_data         <= 16'h0000;
      buffer_write_pulse        <= 1'b0;
      buffer_read_pulse         <= 1'b0;
      command_pulse             <= 1'b0;
    end
    else
    begin
      sync_mode                 <= strap_sync;
      state                     <= next_state;
      sel_latched               <= next_sel_latched;
      mask1_low                 <= next_mask1_low;
      mask1_high                <= next_mask1_high;
      mask2_low                 <= next_mask2_low;
      mask2_high                <= next_mask2_high;
      scratch                   <= next_scratch;
      operating_state           <= next_operating_state;
      host_data_bus_out         <= next_data_out;
      host_data_bus_oe          <= next_data_oe;
      ready_n_out               <= 1'b0;
      ready_n_oe                <= next_ready_oe;
      first_attention_line_out  <= 1'b0;
      first_attention_line_oe   <= !line1_n;
      second_attention_line_out <= 1'b0;
      second_attention_line_oe  <= !line2_n;
      buffer_write_data         <= next_buffer_write_pulse ? data_eff : buffer_write_data;
      buffer_write_pulse        <= next_buffer_write_pulse;
      buffer_read_pulse         <= next_buffer_read_pulse;
      command_pulse             <= next_command_pulse;
    end
  end

endmodule : node_processor_register_port
`default_nettype wire

// file: np_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module np_port_checker
  import np_port_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       port_timing_strap,
  input wire logic       chip_select_n,
  input wire logic       port_data_strobe_n,
  input wire logic       read_write,
  input wire logic [6:0] register_select_bus,
  input wire logic       host_data_bus_oe,
  input wire logic       ready_n_oe,
  input wire logic       first_attention_line_oe,
  input wire logic       second_attention_line_oe,
  input wire logic       buffer_transfer_pending,
  input wire logic [7:0] operating_state,
  input wire logic       command_pulse
);
  logic [3:0] calm;
  logic       syn;
  logic       asy;
  // Strap filter settles within eight edges
  always_ff @(posedge clk or posedge reset)
    if (reset)
      calm <= 4'h0;
    else if (calm != 4'h8)
      calm <= calm + 4'h1;
  assign syn = port_timing_strap && calm == 4'h8;
  assign asy = !port_timing_strap && calm == 4'h8;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_sync_bus_drive: assert property (syn && !chip_select_n && read_write |=> host_data_bus_oe)
    else $error("sync read not driving bus");
  a_async_bus_off: assert property ((asy && port_data_strobe_n) [*6] |-> !host_data_bus_oe)
    else $error("async bus driven without strobe");
  a_idle_bus_off: assert property ((chip_select_n && calm == 4'h8) [*6] |-> !host_data_bus_oe)
    else $error("bus driven while deselected");
  a_ack_one_cycle: assert property (syn && $rose(ready_n_oe) |=> !ready_n_oe)
    else $error("sync acknowledge longer than one cycle");
  a_sync_ack_cause: assert property (syn && $rose(ready_n_oe) |-> $past(!chip_select_n && !port_data_strobe_n))
    else $error("sync acknowledge without strobe");
  a_async_ack_cause: assert property (asy && $rose(ready_n_oe) |-> $past(!chip_select_n && !port_data_strobe_n))
    else $error("async acknowledge without request");
  a_async_ack_drop: assert property ((asy && port_data_strobe_n) [*6] |-> !ready_n_oe)
    else $error("async acknowledge held after strobe high");
  a_buf_ack_wait: assert property (syn && buffer_transfer_pending && $past(buffer_transfer_pending)
    && register_select_bus == SEL_BUFFER_DATA && $past(register_select_bus) == SEL_BUFFER_DATA
    |=> !ready_n_oe)
    else $error("buffer window acknowledged while pending");
  a_attn1_drop: assert property (syn && $rose(ready_n_oe) && $past(read_write && register_select_bus[6:1] == 6'h00)
    |-> ##[0:3] !first_attention_line_oe)
    else $error("first attention kept after status read");
  a_attn2_drop: assert property (syn && $rose(ready_n_oe) && $past(read_write && register_select_bus[6:1] == 6'h01)
    |-> ##[0:3] !second_attention_line_oe)
    else $error("second attention kept after status read");
  a_cmd_state: assert property (command_pulse |=> !command_pulse && operating_state[7:6] == 2'b01)
    else $error("command pulse or state wrong");
  c_sync_ack: cover property (syn && $rose(ready_n_oe));
  c_async_ack: cover property (asy && $rose(ready_n_oe));
  c_cmd: cover property (command_pulse);
endmodule : np_port_checker
bind node_processor_register_port np_port_checker i_chk (
  .clk(clk), .reset(reset), .port_timing_strap(port_timing_strap), .chip_select_n(chip_select_n),
  .port_data_strobe_n(port_data_strobe_n), .read_write(read_write), .register_select_bus(register_select_bus),
  .host_data_bus_oe(host_data_bus_oe), .ready_n_oe(ready_n_oe), .first_attention_line_oe(first_attention_line_oe),
  .second_attention_line_oe(second_attention_line_oe), .buffer_transfer_pending(buffer_transfer_pending),
  .operating_state(operating_state), .command_pulse(command_pulse)
);
`default_nettype wire

// file: np_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module np_master_model
  import np_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        ack_n,
  input  wire logic [15:0] dut_q,
  input  wire logic        dut_oe,
  output var  logic        cs_n,
  output var  logic        ds_n,
  output var  logic        rw,
  output var  logic [6:0]  sel,
  output wire logic [15:0] bus,
  output var  logic        got,
  output var  logic [15:0] got_q
);
  logic [15:0] wd;
  logic [15:0] last;
  logic        drv;
  initial
  begin
    cs_n = 1'b1;
    ds_n = 1'b1;
    rw = 1'b1;
    sel = 7'h00;
    wd = 16'h0000;
    drv = 1'b0;
    got = 1'b0;
    got_q = 16'h0000;
    last = 16'h0000;
  end
  // Undriven bus shows a pattern that keeps changing
  assign bus = dut_oe ? dut_q : drv ? wd : ~last;
  always @(posedge clk)
    last <= bus;
  task automatic access(input logic r, input logic [6:0] a, input logic [15:0] d);
    int k;
    @(negedge clk);
    rw = r;
    sel = a;
    wd = d;
    drv = !r;
    cs_n = 1'b0;
    ds_n = 1'b0;
    for (k = 0; k < 60 && ack_n !== 1'b0; k++)
      @(negedge clk);
    got_q = bus;
    got = r;
    cs_n = 1'b1;
    ds_n = 1'b1;
    drv = 1'b0;
    @(negedge clk);
    got = 1'b0;
    for (k = 0; k < 60 && ack_n !== 1'b1; k++)
      @(negedge clk);
  endtask : access
  // Strobe with chip select left high
  task automatic stray(input int n);
    @(negedge clk);
    ds_n = 1'b0;
    repeat (n) @(negedge clk);
    ds_n = 1'b1;
  endtask : stray
endmodule : np_master_model
`default_nettype wire

// file: test_node_processor_register_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_node_processor_register_port
  import np_port_pkg::*;
  ;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        strap = 1'b1;
  logic        pend = 1'b0;
  logic [31:0] ev1 = 32'h0;
  logic [31:0] ev2 = 32'h0;
  logic [15:0] brd = 16'h0;
  logic [31:0] seed = 32'h00012D63;
  logic [15:0] exp_q[$];
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n_bw = 0;
  int          n_br = 0;
  logic        cs_n, ds_n, rw, got, q_oe, rdy_out, ack, a1, a2, bwp, brp;
  logic [6:0]  sel;
  logic [7:0]  op;
  logic [15:0] bus, got_q, q, bwd;
  wire  logic [1:0] att = {a2, a1};
  node_processor_register_port i_dut (
    .clk(clk), .reset(reset), .port_timing_strap(strap), .chip_select_n(cs_n),
    .port_data_strobe_n(ds_n), .read_write(rw), .register_select_bus(sel),
    .host_data_bus_in(bus), .host_data_bus_out(q), .host_data_bus_oe(q_oe),
    .ready_n_out(rdy_out), .ready_n_oe(ack), .first_attention_line_out(),
    .first_attention_line_oe(a1), .second_attention_line_out(), .second_attention_line_oe(a2),
    .status1_events(ev1), .status2_events(ev2), .buffer_transfer_pending(pend),
    .buffer_read_data(brd), .buffer_write_data(bwd), .buffer_write_pulse(bwp), .buffer_read_pulse(brp),
    .operating_state(op), .command_pulse()
  );
  np_master_model i_bus (
    .clk(clk), .ack_n(ack ? rdy_out : 1'b1), .dut_q(q), .dut_oe(q_oe), .cs_n(cs_n),
    .ds_n(ds_n), .rw(rw), .sel(sel), .bus(bus), .got(got), .got_q(got_q)
  );
  always #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_bus.access(1'b1, a, 16'h0000);
    check({15'h0, ack}, 16'h0000);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_bus.access(1'b0, a, d);
    check({15'h0, ack}, 16'h0000);
  endtask : wr
  task automatic pulse(input int k, input logic [31:0] b);
    @(negedge clk);
    ev1 = (k == 0) ? b : 32'h0;
    ev2 = (k == 1) ? b : 32'h0;
    @(negedge clk);
    ev1 = 32'h0;
    ev2 = 32'h0;
    repeat (4) @(negedge clk);
  endtask : pulse
  task automatic run_reset();
    @(negedge clk);
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
  endtask : run_reset
  // Each finished read is compared with the oldest note
  always @(posedge clk)
    if (got === 1'b1)
      check(got_q, exp_q.pop_front());
  // Buffer window strobes, one per access
  always @(posedge clk)
  begin
    n_bw += bwp;
    n_br += brp;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic [6:0]  c;
    logic [6:0]  lo;
    logic [6:0]  hi;
    run_reset();
    check({8'h00, op}, {8'h00, RESET_OP_STATE});
    rd(SEL_SCRATCH, RESET_SCRATCH);
    r = rnd();
    wr(SEL_SCRATCH, r[15:0]);
    rd(SEL_SCRATCH, r[15:0]);
    wr(7'h0B, 16'hFFFF);
    rd(7'h0B, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      c = (i == 0) ? CMD_BASE : (i == 1) ? 7'h7F : {1'b1, r[5:0]};
      wr(c, r[15:0]);
      check({8'h00, op}, {9'h000, c});
      rd(SEL_STATE_READ, {9'h000, c});
    end
    for (int k = 0; k < 2; k++)
    begin
      lo = k ? SEL_STATUS2_LOW : SEL_STATUS1_LOW;
      hi = k ? SEL_STATUS2_HIGH : SEL_STATUS1_HIGH;
      wr(k ? SEL_MASK2_LOW : SEL_MASK1_LOW, 16'h0001);
      pulse(k, 32'h0004_0002);
      check({15'h0, att[k]}, 16'h0000);
      pulse(k, 32'h0000_0001);
      check({15'h0, att[k]}, 16'h0001);
      rd(lo, 16'h0003);
      check({15'h0, att[k]}, 16'h0000);
      pulse(k, 32'h0000_0001);
      check({15'h0, att[k]}, 16'h0000);
      rd(lo, 16'h0001);
      rd(hi, 16'h0004);
      pulse(k, 32'h0000_0001);
      check({15'h0, att[k]}, 16'h0001);
      rd(lo, 16'h0001);
      rd(hi, 16'h0000);
    end
    r = rnd();
    brd = r[31:16];
    pend = 1'b1;
    fork
      rd(SEL_BUFFER_DATA, r[31:16]);
      begin
        repeat (8) @(negedge clk);
        check({15'h0, ack}, 16'h0000);
        pend = 1'b0;
      end
    join
    wr(SEL_BUFFER_DATA, r[15:0]);
    check(bwd, r[15:0]);
    check(n_bw[15:0], 16'h0001);
    check(n_br[15:0], 16'h0001);
    i_bus.stray(4);
    check({15'h0, ack}, 16'h0000);
    check({8'h00, op}, {9'h000, c});
    strap = 1'b0;
    run_reset();
    r = rnd();
    wr(SEL_SCRATCH, r[15:0]);
    rd(SEL_SCRATCH, r[15:0]);
    check({15'h0, q_oe}, 16'h0000);
    wr(7'h41, 16'h0000);
    check({8'h00, op}, 16'h0041);
    final_report();
  end
endmodule : test_node_processor_register_port
`default_nettype wire
